// [verilog/ext_irq_pkg.sv]
// Constants, types and register map of the external pin interrupt and wake block
`default_nettype none
package ext_irq_pkg;
  // Clock and watchdog oscillator timing
  localparam int CLK_PERIOD_PS = 4000;
  localparam int WDT_PERIOD_PS = 1000000;
  localparam int WDT_TICK_CYC = (WDT_PERIOD_PS / CLK_PERIOD_PS) < 1 ? 1 : (WDT_PERIOD_PS / CLK_PERIOD_PS);
  localparam int WDT_CNT_W = $clog2(WDT_TICK_CYC + 1);

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_SLEEP = 8'h04;
  localparam logic [7:0] OFS_STAT = 8'h08;
  localparam logic [7:0] OFS_MASK = 8'h0C;
  localparam logic [7:0] OFS_PINS = 8'h10;

  // Field positions
  localparam int PIN_LVL_LSB = 8;
  localparam int WAKE_BIT = 3;
  localparam int STAT_W = 4;

  // Sense codes for lines zero and one
  localparam logic [1:0] SENSE_LOW = 2'h0;
  localparam logic [1:0] SENSE_ANY = 2'h1;
  localparam logic [1:0] SENSE_FALL = 2'h2;
  localparam logic [1:0] SENSE_RISE = 2'h3;

  // Sleep mode codes
  localparam logic [1:0] SLP_NONE = 2'h0;
  localparam logic [1:0] SLP_IDLE = 2'h1;
  localparam logic [1:0] SLP_DOWN = 2'h2;

  // Start-up lengths in watchdog ticks, by fuse setting
  localparam logic [7:0] START_TICKS_0 = 8'h01;
  localparam logic [7:0] START_TICKS_1 = 8'h04;
  localparam logic [7:0] START_TICKS_2 = 8'h10;
  localparam logic [7:0] START_TICKS_3 = 8'h40;

  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic [2:0] en;
    logic line_two_edge_select;
    logic line_one_sense_hi;
    logic line_one_sense_lo;
    logic line_zero_sense_hi;
    logic line_zero_sense_lo;
  } ctrl_s;

  typedef struct packed {
    logic [2:0] dir;
    logic [2:0] out;
  } pins_s;

  localparam ctrl_s CTRL_RST = '0;
  localparam pins_s PINS_RST = '0;

  typedef enum logic [1:0] {PWR_RUN, PWR_IDLE, PWR_DOWN, PWR_START} pwr_e;
endpackage : ext_irq_pkg
`default_nettype wire

// [verilog/ext_irq_wake.sv]
// External pin interrupt detection, request flags and sleep wake-up control
// Summary of operation
// - An enabled line raises requests from pin activity even when the pin is driven as an output.
// - Lines zero and one offer falling, rising and low-level sense; line two offers edges only.
// - A line zero or one in level mode requests continuously while its pin is low.
// - Edge sensing on lines zero and one runs only while the I/O clock runs.
// - Low level on lines zero and one and edges on line two work in every sleep mode and wake the part.
// - The I/O clock stops in every sleep mode except idle and runs in idle.
// - A level wake from power-down needs the level on two watchdog oscillator ticks of 1 us.
// - The part wakes after two good samples, completing the fuse-selected start-up time.
// - If the level is gone at the end of start-up the part wakes but no level request follows.
// - Lines zero and one have a two-bit sense: 00 low, 01 any change, 10 falling, 11 rising.
// - Line two has an edge select, 0 falling and 1 rising, and changing it may raise a request.
// - An edge sets the line's flag, cleared on service or by writing one, held clear in level mode.
// - Edge and change pulses longer than one clock period on lines zero and one are caught.
`default_nettype none
module ext_irq_wake
  import ext_irq_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic ext_irq_line_zero,
  input wire logic ext_irq_line_one,
  input wire logic ext_irq_line_two,
  output logic [2:0] pin_drive,
  output logic [2:0] pin_drive_en,
  input wire logic [1:0] startup_time_fuses,
  input wire logic [2:0] irq_ack,
  output logic [2:0] irq_req,
  output logic irq,
  output logic io_clk_run,
  output logic asleep
);

  function automatic logic edge_hit(logic [1:0] sense, logic cur, logic prev);
    logic hit;
    hit = 1'b0;
    unique case (sense)
      SENSE_ANY: hit = cur ^ prev;
      SENSE_FALL: hit = prev & ~cur;
      SENSE_RISE: hit = cur & ~prev;
      SENSE_LOW: hit = 1'b0;
    endcase
    return hit;
  endfunction

  function automatic logic [7:0] startup_ticks(logic [1:0] fuses);
    logic [7:0] t = START_TICKS_0;
    unique case (fuses)
      2'h0: t = START_TICKS_0;
      2'h1: t = START_TICKS_1;
      2'h2: t = START_TICKS_2;
      2'h3: t = START_TICKS_3;
    endcase
    return t;
  endfunction

  ctrl_s ctrl_q;
  pins_s pins_q;
  logic [STAT_W-1:0] stat_q, stat_d, mask_q;
  logic [2:0] s1_q, s2_q, prev_q, eff_pin, ev, lvl, w1c;
  logic [1:0] sense0, sense1, samp_q, sleep_mode;
  pwr_e pwr_q, pwr_d;
  logic [WDT_CNT_W-1:0] wdt_cnt_q;
  logic [7:0] start_cnt_q, aw_addr_q;
  logic t2_q, t2, wdt_tick, start_done, lvl_any, wake_now, sleep_wr;
  logic aw_full_q, w_full_q, wr_go, rd_go;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;

  assign sense0 = {ctrl_q.line_zero_sense_hi, ctrl_q.line_zero_sense_lo};
  assign sense1 = {ctrl_q.line_one_sense_hi, ctrl_q.line_one_sense_lo};

  // Pin drive and effective pin level
  assign pin_drive = pins_q.out;
  assign pin_drive_en = pins_q.dir;
  assign eff_pin = (pins_q.dir & pins_q.out) | (~pins_q.dir & {ext_irq_line_two, ext_irq_line_one, ext_irq_line_zero});

  // Two-stage synchronizer and previous sample
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s1_q <= 3'h7;
      s2_q <= 3'h7;
      prev_q <= 3'h7;
    end else if (ce) begin
      s1_q <= eff_pin;
      s2_q <= s1_q;
      prev_q <= s2_q;
    end
  end

  // Line two polarity-adjusted level
  assign t2 = ctrl_q.line_two_edge_select ? s2_q[2] : ~s2_q[2];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      t2_q <= 1'b0;
    end else if (ce) begin
      t2_q <= t2;
    end
  end

  // Edge events and level requests
  assign io_clk_run = (pwr_q == PWR_RUN) || (pwr_q == PWR_IDLE);
  assign ev[0] = io_clk_run && edge_hit(sense0, s2_q[0], prev_q[0]);
  assign ev[1] = io_clk_run && edge_hit(sense1, s2_q[1], prev_q[1]);
  assign ev[2] = t2 && !t2_q;
  assign lvl[0] = (sense0 == SENSE_LOW) && !s2_q[0];
  assign lvl[1] = (sense1 == SENSE_LOW) && !s2_q[1];
  assign lvl[2] = 1'b0;
  assign lvl_any = |(lvl[1:0] & ctrl_q.en[1:0]);

  // Requests toward the core
  assign irq_req[0] = ctrl_q.en[0] && (lvl[0] || stat_q[0]);
  assign irq_req[1] = ctrl_q.en[1] && (lvl[1] || stat_q[1]);
  assign irq_req[2] = ctrl_q.en[2] && stat_q[2];
  assign irq = |(stat_q & mask_q) || |(lvl & mask_q[2:0]);
  assign asleep = (pwr_q != PWR_RUN);

  // Sticky status; set wins over clear, flags held clear in level mode
  always_comb begin
    stat_d = (stat_q & ~{1'b0, irq_ack}) & ~{wr_go && aw_addr_q == OFS_STAT && w_strb_q[0] ? w_data_q[WAKE_BIT] : 1'b0, w1c};
    stat_d[2:0] = stat_d[2:0] | ev;
    if (sense0 == SENSE_LOW) begin
      stat_d[0] = 1'b0;
    end
    if (sense1 == SENSE_LOW) begin
      stat_d[1] = 1'b0;
    end
    if (wake_now) begin
      stat_d[WAKE_BIT] = 1'b1;
    end
  end

  assign w1c = (wr_go && aw_addr_q == OFS_STAT && w_strb_q[0]) ? w_data_q[2:0] : 3'h0;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stat_q <= '0;
    end else if (ce) begin
      stat_q <= stat_d;
    end
  end

  // Watchdog oscillator tick
  assign wdt_tick = (wdt_cnt_q == WDT_CNT_W'(WDT_TICK_CYC - 1));

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wdt_cnt_q <= '0;
    end else if (ce) begin
      wdt_cnt_q <= wdt_tick ? '0 : wdt_cnt_q + 1'b1;
    end
  end

  // Power-down level qualification by two watchdog samples
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      samp_q <= 2'h0;
    end else if (ce) begin
      if (pwr_q != PWR_DOWN) begin
        samp_q <= 2'h0;
      end else if (wdt_tick) begin
        samp_q <= lvl_any ? samp_q + 2'h1 : 2'h0;
      end
    end
  end

  // Start-up timer in watchdog ticks
  assign start_done = (pwr_q == PWR_START) && wdt_tick && (start_cnt_q + 8'h01 >= startup_ticks(startup_time_fuses));

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      start_cnt_q <= 8'h00;
    end else if (ce) begin
      if (pwr_q != PWR_START) begin
        start_cnt_q <= 8'h00;
      end else if (wdt_tick) begin
        start_cnt_q <= start_cnt_q + 8'h01;
      end
    end
  end

  // Sleep request from software
  assign sleep_wr = wr_go && aw_addr_q == OFS_SLEEP && w_strb_q[0];
  assign sleep_mode = w_data_q[1:0];

  // Power state machine
  always_comb begin
    pwr_d = pwr_q;
    wake_now = 1'b0;
    unique case (pwr_q)
      PWR_RUN: begin
        if (sleep_wr && sleep_mode == SLP_IDLE) begin
          pwr_d = PWR_IDLE;
        end else if (sleep_wr && sleep_mode == SLP_DOWN) begin
          pwr_d = PWR_DOWN;
        end
      end
      PWR_IDLE: begin
        if (|irq_req || |(ev & ctrl_q.en)) begin
          pwr_d = PWR_RUN;
          wake_now = 1'b1;
        end
      end
      PWR_DOWN: begin
        if (ev[2] && ctrl_q.en[2]) begin
          pwr_d = PWR_START;
        end else if (wdt_tick && lvl_any && samp_q == 2'h1) begin
          pwr_d = PWR_START;
        end
      end
      PWR_START: begin
        if (start_done) begin
          pwr_d = PWR_RUN;
          wake_now = 1'b1;
        end
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pwr_q <= PWR_RUN;
    end else if (ce) begin
      pwr_q <= pwr_d;
    end
  end

  // AXI4-Lite write channel
  assign s_axi_awready = ce && !aw_full_q && !s_axi_bvalid;
  assign s_axi_wready = ce && !w_full_q && !s_axi_bvalid;
  assign wr_go = aw_full_q && w_full_q && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_q <= 1'b0;
      w_full_q <= 1'b0;
      aw_addr_q <= 8'h00;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (ce) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_full_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_full_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_full_q <= 1'b0;
        w_full_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (aw_addr_q > OFS_PINS || aw_addr_q[1:0] != 2'h0) ? RESP_SLVERR : RESP_OKAY;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Control, mask and pin registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q <= CTRL_RST;
      mask_q <= '0;
      pins_q <= PINS_RST;
    end else if (ce && wr_go && w_strb_q[0]) begin
      if (aw_addr_q == OFS_CTRL) begin
        ctrl_q <= ctrl_s'(w_data_q[7:0]);
      end
      if (aw_addr_q == OFS_MASK) begin
        mask_q <= w_data_q[STAT_W-1:0];
      end
      if (aw_addr_q == OFS_PINS) begin
        pins_q <= pins_s'(w_data_q[5:0]);
      end
    end
  end

  // AXI4-Lite read channel
  assign s_axi_arready = ce && !s_axi_rvalid;
  assign rd_go = s_axi_arvalid && s_axi_arready;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else if (ce) begin
      if (rd_go) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= RESP_OKAY;
        unique case (s_axi_araddr)
          OFS_CTRL: s_axi_rdata <= {24'h000000, ctrl_q};
          OFS_SLEEP: s_axi_rdata <= {30'h00000000, pwr_q};
          OFS_STAT: s_axi_rdata <= {{(32 - STAT_W){1'b0}}, stat_q};
          OFS_MASK: s_axi_rdata <= {{(32 - STAT_W){1'b0}}, mask_q};
          OFS_PINS: s_axi_rdata <= {21'h000000, s2_q, 2'h0, pins_q};
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // Checks
  AST_OUT_PIN_SEEN: assert property (@(posedge aclk) disable iff (!aresetn)
    (ce && pins_q.dir[2]) |=> (s1_q[2] == $past(pins_q.out[2])))
    else $error("Driven pin level not sampled");
  AST_LEVEL_REQ: assert property (@(posedge aclk) disable iff (!aresetn)
    (ctrl_q.en[0] && sense0 == SENSE_LOW && !s2_q[0]) |-> irq_req[0])
    else $error("Level request missing while pin low");
  AST_LEVEL_FLAG_CLEAR: assert property (@(posedge aclk) disable iff (!aresetn)
    (ce && sense1 == SENSE_LOW) |=> !stat_q[1])
    else $error("Flag set in level mode");
  AST_SET_WINS: assert property (@(posedge aclk) disable iff (!aresetn)
    (ce && ev[0] && sense0 != SENSE_LOW) |=> stat_q[0])
    else $error("Edge event lost");
  AST_EDGE_NEEDS_IO: assert property (@(posedge aclk) disable iff (!aresetn)
    (ce && !io_clk_run) |-> (ev[1:0] == 2'h0))
    else $error("Edge detected with I/O clock stopped");
  AST_IO_CLK_STOP: assert property (@(posedge aclk) disable iff (!aresetn)
    (pwr_q == PWR_DOWN || pwr_q == PWR_START) |-> !io_clk_run)
    else $error("I/O clock running in deep sleep");
  AST_TWO_SAMPLES: assert property (@(posedge aclk) disable iff (!aresetn)
    (pwr_q == PWR_START && $past(pwr_q) == PWR_DOWN && !$past(ev[2]))
      |-> ($past(samp_q) == 2'h1 && $past(wdt_tick) && $past(lvl_any)))
    else $error("Level wake without two samples");
  AST_LINE_TWO_WAKE: assert property (@(posedge aclk) disable iff (!aresetn)
    (ce && pwr_q == PWR_DOWN && ev[2] && ctrl_q.en[2]) |=> (pwr_q == PWR_START))
    else $error("Line two edge did not wake");
  AST_STARTUP_END: assert property (@(posedge aclk) disable iff (!aresetn)
    (ce && start_done) |=> (pwr_q == PWR_RUN && stat_q[WAKE_BIT]))
    else $error("Start-up end did not wake");

endmodule : ext_irq_wake
`default_nettype wire

// [verification/ext_src_model.sv]
// External signal sources driving the three interrupt pins
`default_nettype none
module ext_src_model (
  input wire logic aclk,
  input wire logic [2:0] lvl,
  input wire logic [2:0] hold_req,
  input wire logic asleep,
  input wire logic [2:0] pin_drive,
  input wire logic [2:0] pin_drive_en,
  output logic [2:0] line
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] hold_q = 3'h0;
  // Wake level held low until the part is awake again
  always @(posedge aclk) begin
    hold_q <= (hold_q & {3{asleep}}) | hold_req;
  end
  // A pin driven as output shows the driven value
  assign line = (pin_drive_en & pin_drive) | (~pin_drive_en & lvl & ~hold_q);
endmodule // ext_src_model
`default_nettype wire

// [verification/tb.sv]
// Self-checking testbench of the external pin interrupt and wake block
`default_nettype none
module tb
  import ext_irq_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk, aresetn, irq, io_clk_run, asleep;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [1:0] s_axi_bresp, s_axi_rresp, startup_time_fuses;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [2:0] lvl, hold_req, line, pin_drive, pin_drive_en, irq_ack, irq_req;
  int miscompares = 0;
  int compares = 0;
  int n;

  ext_irq_wake ext_irq_wake_inst (.aclk, .aresetn, .ce(1'b1), .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .ext_irq_line_zero(line[0]), .ext_irq_line_one(line[1]), .ext_irq_line_two(line[2]), .pin_drive,
    .pin_drive_en, .startup_time_fuses, .irq_ack, .irq_req, .irq, .io_clk_run, .asleep);
  ext_src_model ext_src_model_inst (.aclk, .lvl, .hold_req, .asleep, .pin_drive, .pin_drive_en, .line);

  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end

  task automatic summarize();
    if (miscompares == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic timeout();
    miscompares++;
    summarize();
  endtask

  task automatic chk(input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      $display("Error at %0t: expected %h, got %h", $time, e, g);
      miscompares++;
    end
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge aclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = RESP_OKAY);
    logic aw = 1'b1;
    logic w = 1'b1;
    logic b = 1'b0;
    int k = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!b && k < 100) begin
      @(posedge aclk);
      k++;
      if (aw && s_axi_awready) begin
        aw = 1'b0;
        s_axi_awvalid <= 1'b0;
      end
      if (w && s_axi_wready) begin
        w = 1'b0;
        s_axi_wvalid <= 1'b0;
      end
      if (s_axi_bvalid) begin
        b = 1'b1;
        s_axi_bready <= 1'b0;
        chk(32'(er), 32'(s_axi_bresp));
      end
    end
    if (!b) timeout();
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er = RESP_OKAY);
    logic ar = 1'b1;
    logic r = 1'b0;
    int k = 0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!r && k < 100) begin
      @(posedge aclk);
      k++;
      if (ar && s_axi_arready) begin
        ar = 1'b0;
        s_axi_arvalid <= 1'b0;
      end
      if (s_axi_rvalid) begin
        r = 1'b1;
        s_axi_rready <= 1'b0;
        chk(e, s_axi_rdata);
        chk(32'(er), 32'(s_axi_rresp));
      end
    end
    if (!r) timeout();
  endtask

  task automatic wake(input int lim, output int k);
    k = 0;
    while (asleep !== 1'b0 && k < lim) begin
      @(posedge aclk);
      k++;
    end
    if (k >= lim) timeout();
  endtask

  task automatic t_reset();
    @(posedge aclk);
    chk({io_clk_run, asleep, irq, irq_req}, 6'h20);
    rd(OFS_CTRL, 32'h0);
    rd(OFS_STAT, 32'h0);
    rd(OFS_MASK, 32'h0);
    rd(OFS_SLEEP, 32'h0);
    rd(OFS_PINS, 32'h700);
    rd(8'h14, 32'h0, RESP_SLVERR);
    wr(8'h14, 32'hF, RESP_SLVERR);
  endtask

  task automatic t_edges();
    for (int l = 0; l < 2; l++) begin
      for (int c = 1; c < 4; c++) begin
        wr(OFS_CTRL, 32'hE0 | (c << (2 * l)));
        wr(OFS_STAT, 32'hF);
        lvl[l] <= 1'b0;
        cyc(8);
        rd(OFS_STAT, 32'(c != 3) << l);
        chk(irq_req[l], c != 3);
        wr(OFS_STAT, 32'hF);
        lvl[l] <= 1'b1;
        cyc(8);
        rd(OFS_STAT, 32'(c != 2) << l);
      end
    end
    wr(OFS_CTRL, 32'hE2);
    wr(OFS_STAT, 32'hF);
    lvl[0] <= 1'b0;
    cyc(2);
    lvl[0] <= 1'b1;
    cyc(8);
    rd(OFS_STAT, 32'h1);
    chk(irq, 1'b0);
    wr(OFS_MASK, 32'h1);
    cyc(1);
    chk(irq, 1'b1);
    irq_ack <= 3'h1;
    cyc(1);
    irq_ack <= 3'h0;
    cyc(2);
    chk(irq, 1'b0);
    rd(OFS_STAT, 32'h0);
  endtask

  task automatic t_level();
    wr(OFS_CTRL, 32'hE0);
    lvl[0] <= 1'b0;
    cyc(4);
    chk({irq_req[0], irq}, 2'h3);
    cyc(40);
    chk({irq_req[0], irq}, 2'h3);
    rd(OFS_STAT, 32'h0);
    lvl[0] <= 1'b1;
    cyc(4);
    chk({irq_req[0], irq}, 2'h0);
  endtask

  task automatic t_output();
    wr(OFS_CTRL, 32'hFA);
    wr(OFS_PINS, 32'h20);
    cyc(4);
    chk({pin_drive_en, pin_drive}, 6'h20);
    wr(OFS_STAT, 32'hF);
    wr(OFS_PINS, 32'h24);
    cyc(8);
    rd(OFS_STAT, 32'h4);
    rd(OFS_PINS, 32'h724);
    wr(OFS_CTRL, 32'hEA);
    wr(OFS_STAT, 32'hF);
    wr(OFS_PINS, 32'h20);
    cyc(8);
    rd(OFS_STAT, 32'h4);
    wr(OFS_STAT, 32'hF);
    wr(OFS_PINS, 32'h0);
    cyc(8);
    rd(OFS_STAT, 32'h0);
  endtask

  task automatic t_down();
    wr(OFS_CTRL, 32'hE8);
    wr(OFS_STAT, 32'hF);
    wr(OFS_SLEEP, 32'h2);
    cyc(2);
    chk({io_clk_run, asleep}, 2'h1);
    lvl[1] <= 1'b0;
    cyc(8);
    lvl[1] <= 1'b1;
    cyc(8);
    rd(OFS_STAT, 32'h0);
    rd(OFS_SLEEP, 32'h2);
    hold_req <= 3'h1;
    cyc(1);
    hold_req <= 3'h0;
    wake(3000, n);
    chk(irq_req[0], 1'b1);
    chk(n > 250, 1'b1);
    cyc(4);
    rd(OFS_STAT, 32'h8);
  endtask

  task automatic t_short();
    startup_time_fuses <= 2'h3;
    wr(OFS_STAT, 32'hF);
    wr(OFS_SLEEP, 32'h2);
    lvl[0] <= 1'b0;
    cyc(600);
    lvl[0] <= 1'b1;
    cyc(4);
    chk(asleep, 1'b1);
    wake(20000, n);
    cyc(4);
    chk(irq_req[0], 1'b0);
    rd(OFS_STAT, 32'h8);
  endtask

  task automatic t_idle();
    startup_time_fuses <= 2'h0;
    wr(OFS_STAT, 32'hF);
    wr(OFS_SLEEP, 32'h1);
    cyc(2);
    chk({io_clk_run, asleep}, 2'h3);
    lvl[1] <= 1'b0;
    wake(50, n);
    lvl[1] <= 1'b1;
    cyc(8);
    chk(irq_req[1], 1'b1);
  endtask

  task automatic t_two_wake();
    wr(OFS_STAT, 32'hF);
    wr(OFS_SLEEP, 32'h2);
    lvl[2] <= 1'b0;
    wake(600, n);
    chk(irq_req[2], 1'b1);
    rd(OFS_STAT, 32'hC);
    lvl[2] <= 1'b1;
  endtask

  initial begin
    aresetn = 1'b0;
    lvl = 3'h7;
    hold_req = 3'h0;
    irq_ack = 3'h0;
    startup_time_fuses = 2'h0;
    s_axi_awaddr = 8'h0;
    s_axi_araddr = 8'h0;
    s_axi_wdata = 32'h0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_edges();
    t_level();
    t_output();
    t_down();
    t_short();
    t_idle();
    t_two_wake();
    summarize();
  end
endmodule // tb
`default_nettype wire
